/* File: hdl/line_monitor_pkg.sv */
// Constants, register map and carrier types for the line power and loop closure monitor.
// Assumes a 32-bit APB master; register index n sits at byte address 4*n.
package line_monitor_pkg;
    // Direct register indices
    localparam logic [6:0] IDX_PENDING     = 7'h13;
    localparam logic [6:0] IDX_ENABLE      = 7'h16;
    localparam logic [6:0] IDX_IND_DATA_LO = 7'h1C;
    localparam logic [6:0] IDX_IND_DATA_HI = 7'h1D;
    localparam logic [6:0] IDX_IND_READ    = 7'h1E;
    localparam logic [6:0] IDX_IND_WRITE   = 7'h1F;
    localparam logic [6:0] IDX_AUTO_OPEN   = 7'h43;
    localparam logic [6:0] IDX_LC_STATUS   = 7'h44;
    localparam logic [6:0] IDX_DEBOUNCE    = 7'h45;
    localparam logic [6:0] IDX_PWR_SELECT  = 7'h4C;
    localparam logic [6:0] IDX_PWR_READOUT = 7'h4D;
    localparam logic [6:0] IDX_LC_SAMPLE   = 7'h4F;
    localparam logic [6:0] IDX_LC_MODE     = 7'h6C;
    // Indirect register indices
    localparam logic [7:0] IND_LC_UPPER    = 8'h0F;
    localparam logic [7:0] IND_PWR_THR_A   = 8'h13;
    localparam logic [7:0] IND_PWR_THR_B   = 8'h14;
    localparam logic [7:0] IND_PWR_THR_C   = 8'h15;
    localparam logic [7:0] IND_LC_FILTER   = 8'h16;
    localparam logic [7:0] IND_POLE_A      = 8'h18;
    localparam logic [7:0] IND_POLE_B      = 8'h19;
    localparam logic [7:0] IND_POLE_C      = 8'h1A;
    localparam logic [7:0] IND_LC_LOWER    = 8'h42;
    // Field positions
    localparam int LC_PEND_BIT     = 1;
    localparam int PWR_PEND_LSB    = 2;
    localparam int HYST_EN_BIT     = 0;
    localparam int VOLT_MODE_BIT   = 2;
    localparam int AUTO_OPEN_BIT   = 0;
    localparam int LC_STATUS_BIT   = 0;
    localparam int PWR_SCALE_SHIFT = 7;
    localparam int FILT_SHIFT      = 15;
    localparam int LC_FRAC_BITS    = 10;
    // Reset values
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    // Linefeed state codes
    localparam logic [2:0] LF_OPEN        = 3'b000;
    localparam logic [2:0] LF_FWD_ACTIVE  = 3'b001;
    localparam logic [2:0] LF_FWD_OHT     = 3'b010;
    localparam logic [2:0] LF_REV_ACTIVE  = 3'b101;
    localparam logic [2:0] LF_REV_OHT     = 3'b110;

    typedef struct packed {
        logic [5:0][7:0] power;
        logic [6:0]      loop_current;
        logic [6:0]      loop_voltage;
        logic [2:0]      linefeed_state_readback;
    } sense_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_s;
endpackage : line_monitor_pkg

/* File: hdl/line_monitor.sv */
// Power alarm and loop closure supervision with an APB register file and indirect access.
// Assumes sense samples are synchronous to pclk and refreshed when sample_tick pulses.
//
// How it works
// - Each transistor power is low-pass filtered and compared with its pair threshold.
// - Filtered power above threshold sets its pending bit; interrupt if enabled.
// - Resolution is 30.4 mW for one, two, five, six; 3.62 mW for three, four.
// - Threshold value is max power over resolution times 2^7.
// - Loop detector processes samples only in active or on-hook transmission states.
// - Loop input is low-pass filtered then compared with its threshold.
// - Debounce output flips only after comparator stays opposite for whole interval.
// - Debounce satisfied sets loop status; interrupt only with its enable.
// - Hysteresis enable at bit 0 uses upper and lower thresholds as bounds.
// - Voltage mode at bit 2 compares loop voltage against a minimum threshold.
// - Voltage mode with hysteresis uses upper and lower voltage boundaries.
// - Thresholds and coefficients are reached only via direct registers 28 to 31.
// - Linefeed readback codes: 000 open, 001, 010, 101, 110 as listed.
`timescale 1ns/1ps
module line_monitor #(
    parameter int NUM_Q = 6
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [31:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     sample_tick,
    input  wire line_monitor_pkg::sense_s sense,
    output logic                          irq,
    output logic                          force_open
);
    import line_monitor_pkg::*;

    // Maps an indirect address to a storage slot, 4'hF when unmapped
    function automatic logic [3:0] ind_slot(input logic [7:0] a);
        if (a == IND_LC_UPPER) begin
            ind_slot = 4'h0;
        end else if (a == IND_PWR_THR_A) begin
            ind_slot = 4'h1;
        end else if (a == IND_PWR_THR_B) begin
            ind_slot = 4'h2;
        end else if (a == IND_PWR_THR_C) begin
            ind_slot = 4'h3;
        end else if (a == IND_POLE_A) begin
            ind_slot = 4'h4;
        end else if (a == IND_POLE_B) begin
            ind_slot = 4'h5;
        end else if (a == IND_POLE_C) begin
            ind_slot = 4'h6;
        end else if (a == IND_LC_LOWER) begin
            ind_slot = 4'h7;
        end else if (a == IND_LC_FILTER) begin
            ind_slot = 4'h8;
        end else begin
            ind_slot = 4'hF;
        end
    endfunction : ind_slot

    // Direct register decode shared by read and write paths
    function automatic logic is_mapped(input logic [6:0] i);
        is_mapped = (i == IDX_PENDING) || (i == IDX_ENABLE) || (i == IDX_IND_DATA_LO) ||
                    (i == IDX_IND_DATA_HI) || (i == IDX_IND_READ) || (i == IDX_IND_WRITE) ||
                    (i == IDX_AUTO_OPEN) || (i == IDX_LC_STATUS) || (i == IDX_DEBOUNCE) ||
                    (i == IDX_PWR_SELECT) || (i == IDX_PWR_READOUT) || (i == IDX_LC_SAMPLE) ||
                    (i == IDX_LC_MODE);
    endfunction : is_mapped

    logic [7:0]        pending_ff;
    logic [7:0]        enable_ff;
    logic [7:0]        ind_lo_ff;
    logic [7:0]        ind_hi_ff;
    logic [7:0]        ind_addr_ff;
    logic [15:0]       ind_ff [0:8];
    logic              auto_open_ff;
    logic [6:0]        debounce_ff;
    logic [2:0]        pwr_sel_ff;
    logic [7:0]        lc_mode_ff;
    logic [15:0]       filt_ff [0:NUM_Q-1];
    logic [15:0]       nxt_filt [0:NUM_Q-1];
    logic [NUM_Q-1:0]  over;
    logic [15:0]       lc_filt_ff;
    logic [15:0]       nxt_lc_filt;
    logic              lc_status_ff;
    logic [6:0]        lc_count_ff;
    logic              lc_raw;
    logic              lc_active;
    logic              lc_flip;
    logic [5:0]        lc_mag;
    logic [5:0]        lc_level;
    apb_rsp_s          rsp_ff;
    apb_rsp_s          nxt_rsp;
    logic              setup_phase;
    logic              wr_done;
    logic [6:0]        idx;
    logic [3:0]        wr_slot;
    logic [3:0]        rd_slot;
    logic [7:0]        pwr_pend_set;
    logic [7:0]        lc_pend_set;

    assign prdata  = rsp_ff.prdata;
    assign pready  = rsp_ff.pready;
    assign pslverr = rsp_ff.pslverr;

    assign idx         = paddr[8:2];
    assign setup_phase = psel && !penable;
    assign wr_done     = psel && penable && pwrite && rsp_ff.pready && is_mapped(idx) && (paddr[1:0] == 2'b00);
    assign wr_slot     = ind_slot(pwdata[7:0]);
    assign rd_slot     = ind_slot(pwdata[7:0]);

    // Power filters, one per transistor; pole and threshold shared per pair
    genvar gi;
    generate
        for (gi = 0; gi < NUM_Q; gi++) begin : g_q
            logic signed [16:0] diff;
            logic signed [33:0] prod;
            always_comb begin
                diff = $signed({2'b00, sense.power[gi], 7'h00}) - $signed({1'b0, filt_ff[gi]});
                prod = diff * $signed({1'b0, ind_ff[4 + gi / 2]});
                nxt_filt[gi] = 16'(filt_ff[gi] + 16'(prod >>> FILT_SHIFT));
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    filt_ff[gi] <= RST_WORD;
                end else if (sample_tick) begin
                    filt_ff[gi] <= nxt_filt[gi];
                end
            end
            // Thresholds share the fixed point of the filtered value, so the pair's resolution carries over
            assign over[gi] = filt_ff[gi] > ind_ff[1 + gi / 2];
            assign pwr_pend_set[PWR_PEND_LSB + gi] = over[gi];
        end
    endgenerate
    assign pwr_pend_set[PWR_PEND_LSB - 1:0] = 2'b00;

    // Loop closure input selection and filtering
    always_comb begin
        lc_active = (sense.linefeed_state_readback == LF_FWD_ACTIVE) ||
                    (sense.linefeed_state_readback == LF_FWD_OHT) ||
                    (sense.linefeed_state_readback == LF_REV_ACTIVE) ||
                    (sense.linefeed_state_readback == LF_REV_OHT);
        lc_mag = lc_mode_ff[VOLT_MODE_BIT] ? sense.loop_voltage[5:0] : sense.loop_current[5:0];
    end

    always_comb begin
        logic signed [16:0] d;
        logic signed [33:0] p;
        d = $signed({1'b0, lc_mag, 10'h000}) - $signed({1'b0, lc_filt_ff});
        p = d * $signed({1'b0, ind_ff[8]});
        nxt_lc_filt = 16'(lc_filt_ff + 16'(p >>> FILT_SHIFT));
    end

    assign lc_level = lc_filt_ff[15:LC_FRAC_BITS];

    // Comparator with optional hysteresis; voltage mode detects closure below the threshold
    always_comb begin
        lc_raw = 1'b0;
        if (!lc_mode_ff[VOLT_MODE_BIT]) begin
            if (lc_mode_ff[HYST_EN_BIT] && lc_status_ff) begin
                lc_raw = lc_level > ind_ff[7][5:0];
            end else begin
                lc_raw = lc_level > ind_ff[0][5:0];
            end
        end else begin
            if (lc_mode_ff[HYST_EN_BIT]) begin
                lc_raw = lc_status_ff ? (lc_level < ind_ff[0][5:0]) : (lc_level < ind_ff[7][5:0]);
            end else begin
                lc_raw = lc_level < ind_ff[0][5:0];
            end
        end
    end

    assign lc_flip = sample_tick && lc_active && (lc_raw != lc_status_ff) && (lc_count_ff >= debounce_ff);
    assign lc_pend_set = lc_flip ? (8'h01 << LC_PEND_BIT) : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lc_filt_ff <= RST_WORD;
        end else if (sample_tick && lc_active) begin
            lc_filt_ff <= nxt_lc_filt;
        end
    end

    // Debounce counts samples spent in the opposite state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lc_count_ff  <= 7'h00;
            lc_status_ff <= 1'b0;
        end else if (sample_tick && lc_active) begin
            if (lc_raw == lc_status_ff || lc_flip) begin
                lc_count_ff <= 7'h00;
            end else if (lc_count_ff != 7'h7F) begin
                lc_count_ff <= lc_count_ff + 7'h01;
            end
            if (lc_flip) begin
                lc_status_ff <= lc_raw;
            end
        end
    end

    // Pending flags; hardware set wins over a software write-one-to-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_ff <= RST_BYTE;
        end else begin
            if (wr_done && idx == IDX_PENDING) begin
                pending_ff <= (pending_ff & ~pwdata[7:0]) | pwr_pend_set | lc_pend_set;
            end else begin
                pending_ff <= pending_ff | pwr_pend_set | lc_pend_set;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(pending_ff & enable_ff & 8'hFE);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            force_open <= 1'b0;
        end else begin
            force_open <= auto_open_ff && (|over);
        end
    end

    // Direct control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_ff    <= RST_BYTE;
            auto_open_ff <= 1'b0;
            debounce_ff  <= 7'h00;
            pwr_sel_ff   <= 3'b000;
            lc_mode_ff   <= RST_BYTE;
            ind_addr_ff  <= RST_BYTE;
        end else if (wr_done) begin
            if (idx == IDX_ENABLE) begin
                enable_ff <= pwdata[7:0] & 8'hFE;
            end else if (idx == IDX_AUTO_OPEN) begin
                auto_open_ff <= pwdata[AUTO_OPEN_BIT];
            end else if (idx == IDX_DEBOUNCE) begin
                debounce_ff <= pwdata[6:0];
            end else if (idx == IDX_PWR_SELECT) begin
                pwr_sel_ff <= pwdata[2:0];
            end else if (idx == IDX_LC_MODE) begin
                lc_mode_ff <= pwdata[7:0] & 8'h05;
            end else if (idx == IDX_IND_READ || idx == IDX_IND_WRITE) begin
                ind_addr_ff <= pwdata[7:0];
            end
        end
    end

    // Indirect window: data low/high, read trigger, write trigger
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ind_lo_ff <= RST_BYTE;
            ind_hi_ff <= RST_BYTE;
        end else if (wr_done) begin
            if (idx == IDX_IND_DATA_LO) begin
                ind_lo_ff <= pwdata[7:0];
            end else if (idx == IDX_IND_DATA_HI) begin
                ind_hi_ff <= pwdata[7:0];
            end else if (idx == IDX_IND_READ) begin
                ind_lo_ff <= (rd_slot == 4'hF) ? 8'h00 : ind_ff[rd_slot][7:0];
                ind_hi_ff <= (rd_slot == 4'hF) ? 8'h00 : ind_ff[rd_slot][15:8];
            end
        end
    end

    generate
        for (gi = 0; gi < 9; gi++) begin : g_ind
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ind_ff[gi] <= RST_WORD;
                end else if (wr_done && idx == IDX_IND_WRITE && wr_slot == 4'(gi)) begin
                    ind_ff[gi] <= {ind_hi_ff, ind_lo_ff};
                end
            end
        end
    endgenerate

    // APB answer is prepared in the setup cycle, so every access completes without wait states
    always_comb begin
        nxt_rsp = '{prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};
        if (setup_phase) begin
            nxt_rsp.pready = 1'b1;
            if (!is_mapped(idx) || paddr[1:0] != 2'b00) begin
                nxt_rsp.pslverr = 1'b1;
            end else if (!pwrite) begin
                if (idx == IDX_PENDING) begin
                    nxt_rsp.prdata[7:0] = pending_ff;
                end else if (idx == IDX_ENABLE) begin
                    nxt_rsp.prdata[7:0] = enable_ff;
                end else if (idx == IDX_IND_DATA_LO) begin
                    nxt_rsp.prdata[7:0] = ind_lo_ff;
                end else if (idx == IDX_IND_DATA_HI) begin
                    nxt_rsp.prdata[7:0] = ind_hi_ff;
                end else if (idx == IDX_IND_READ || idx == IDX_IND_WRITE) begin
                    nxt_rsp.prdata[7:0] = ind_addr_ff;
                end else if (idx == IDX_AUTO_OPEN) begin
                    nxt_rsp.prdata[AUTO_OPEN_BIT] = auto_open_ff;
                end else if (idx == IDX_LC_STATUS) begin
                    nxt_rsp.prdata[LC_STATUS_BIT] = lc_status_ff;
                end else if (idx == IDX_DEBOUNCE) begin
                    nxt_rsp.prdata[6:0] = debounce_ff;
                end else if (idx == IDX_PWR_SELECT) begin
                    nxt_rsp.prdata[2:0] = pwr_sel_ff;
                end else if (idx == IDX_PWR_READOUT) begin
                    nxt_rsp.prdata[7:0] = (pwr_sel_ff < 3'(NUM_Q)) ? sense.power[pwr_sel_ff] : 8'h00;
                end else if (idx == IDX_LC_SAMPLE) begin
                    nxt_rsp.prdata[6:0] = sense.loop_current;
                end else if (idx == IDX_LC_MODE) begin
                    nxt_rsp.prdata[7:0] = lc_mode_ff;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_ff <= '{prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};
        end else begin
            rsp_ff <= nxt_rsp;
        end
    end
endmodule : line_monitor

/* File: tb/line_monitor_chk.sv */
// Port-level checker for the line monitor, bound to its top module.
// Assumes pclk rising edge and async active-low presetn.
`timescale 1ns/1ps
module line_monitor_chk
    import line_monitor_pkg::*;
#(
    parameter int NUM_Q = 6
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic        force_open
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_done;
        psel && penable && pready;
    endsequence
    sequence s_rd(logic [6:0] idx);
        s_done ##0 (!pwrite && paddr[8:2] == idx);
    endsequence
    sequence s_wr(logic [6:0] idx, logic [31:0] d);
        s_done ##0 (pwrite && paddr[8:2] == idx && pwdata == d);
    endsequence
    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("No ready after setup");
    a_ready_has_cause: assert property (pready |-> $past(psel && !penable))
        else $error("Ready without setup");
    a_idle_rdata_zero: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("Read data outside access");
    a_refused_addr: assert property (s_setup ##0 (paddr[1:0] != 2'b00 || paddr[8:2] == 7'h7F) |=> pslverr)
        else $error("Bad address not refused");
    a_mapped_no_err: assert property (s_setup ##0 (paddr[8:2] == IDX_PENDING && paddr[1:0] == 2'b00) |=> !pslverr)
        else $error("Mapped address refused");
    a_enable_bit_zero: assert property (s_rd(IDX_ENABLE) |-> prdata[31:8] == 24'h00_0000 && !prdata[0])
        else $error("Enable spare bits set");
    a_mode_spare_zero: assert property (s_rd(IDX_LC_MODE) |-> (prdata & 32'hFFFF_FFFA) == 32'h0000_0000)
        else $error("Mode spare bits set");
    a_pointer_width: assert property (s_rd(IDX_PWR_SELECT) |-> prdata[31:3] == 29'h0)
        else $error("Pointer wider than three bits");
    a_irq_off_disabled: assert property (s_wr(IDX_ENABLE, 32'h0000_0000) |-> ##2 !irq)
        else $error("Interrupt with all enables clear");
    a_open_off_manual: assert property (s_wr(IDX_AUTO_OPEN, 32'h0000_0000) |-> ##2 !force_open)
        else $error("Open forced in manual mode");
endmodule : line_monitor_chk

bind line_monitor line_monitor_chk #(.NUM_Q(NUM_Q)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .force_open(force_open)
);

/* File: tb/sense_model.sv */
// Sample source standing in for the converter side of the monitor.
// Assumes the bench sets levels; a tick comes every TICK_DIV clocks.
`timescale 1ns/1ps
module sense_model #(
    parameter int TICK_DIV = 64
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic [5:0][7:0]     q_power,
    input  wire logic [6:0]          cur,
    input  wire logic [6:0]          volt,
    input  wire logic [2:0]          lf,
    output logic                     sample_tick,
    output line_monitor_pkg::sense_s sense
);
    import line_monitor_pkg::*;
    logic [7:0] cnt_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff      <= 8'h00;
            sample_tick <= 1'b0;
        end else begin
            cnt_ff      <= (cnt_ff == 8'(TICK_DIV - 1)) ? 8'h00 : cnt_ff + 8'h01;
            sample_tick <= (cnt_ff == 8'(TICK_DIV - 1));
        end
    end
    assign sense = '{power: q_power, loop_current: cur, loop_voltage: volt, linefeed_state_readback: lf};
endmodule : sense_model

/* File: tb/line_monitor_tb.sv */
// Self-checking bench for the line monitor over APB.
// Assumes sense_model drives the sample side.
`timescale 1ns/1ps
module line_monitor_tb;
    import line_monitor_pkg::*;
    logic            pclk = 1'b0;
    logic            presetn = 1'b0;
    logic            psel = 1'b0;
    logic            penable = 1'b0;
    logic            pwrite = 1'b0;
    logic [31:0]     paddr = 32'h0000_0000;
    logic [31:0]     pwdata = 32'h0000_0000;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic            sample_tick;
    sense_s          sense;
    logic            irq;
    logic            force_open;
    logic [5:0][7:0] q_power = '0;
    logic [6:0]      cur = 7'h00;
    logic [6:0]      volt = 7'h00;
    logic [2:0]      lf = LF_OPEN;
    int              err_count = 0;
    int              compares = 0;
    logic [31:0]     rd;
    logic            err;
    logic [6:0]      rst_idx [7] = '{IDX_PENDING, IDX_ENABLE, IDX_AUTO_OPEN, IDX_LC_STATUS, IDX_DEBOUNCE,
                                     IDX_PWR_SELECT, IDX_LC_MODE};
    logic [7:0]      ind_a [5] = '{IND_PWR_THR_A, IND_PWR_THR_B, IND_PWR_THR_C, IND_POLE_A, IND_POLE_B};
    logic [15:0]     ind_d [5] = '{16'h150D, 16'h1000, 16'h7FFF, 16'h0100, 16'h7FFF};
    // Loop steps: mode, current, voltage, expected status
    logic [2:0]      st_mode [7] = '{3'h0, 3'h1, 3'h1, 3'h4, 3'h4, 3'h5, 3'h5};
    logic [6:0]      st_cur [7] = '{7'h18, 7'h0C, 7'h04, 7'h04, 7'h04, 7'h04, 7'h04};
    logic [6:0]      st_volt [7] = '{7'h00, 7'h00, 7'h00, 7'h04, 7'h18, 7'h0C, 7'h04};
    logic            st_exp [7] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    logic [2:0]      st_lf [7] = '{LF_FWD_ACTIVE, LF_FWD_ACTIVE, LF_FWD_OHT, LF_REV_ACTIVE, LF_REV_OHT,
                                   LF_FWD_ACTIVE, LF_FWD_ACTIVE};

    always #12.5 pclk = ~pclk;

    line_monitor #(.NUM_Q(6)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_tick(sample_tick),
        .sense(sense), .irq(irq), .force_open(force_open)
    );
    sense_model #(.TICK_DIV(64)) u_sense (
        .pclk(pclk), .presetn(presetn), .q_power(q_power), .cur(cur), .volt(volt), .lf(lf),
        .sample_tick(sample_tick), .sense(sense)
    );

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk32
    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask : chk1
    task automatic apb(input logic wr_en, input logic [31:0] addr, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr_en;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [6:0] idx, input logic [31:0] d);
        apb(1'b1, {23'h0, idx, 2'b00}, d);
    endtask : wr
    task automatic rd_chk(input logic [6:0] idx, input logic [31:0] exp);
        apb(1'b0, {23'h0, idx, 2'b00}, 32'h0000_0000);
        chk32(rd, exp);
        chk1(err, 1'b0);
    endtask : rd_chk
    task automatic ind_wr(input logic [7:0] a, input logic [15:0] d);
        wr(IDX_IND_DATA_LO, {24'h0, d[7:0]});
        wr(IDX_IND_DATA_HI, {24'h0, d[15:8]});
        wr(IDX_IND_WRITE, {24'h0, a});
    endtask : ind_wr
    task automatic ind_chk(input logic [7:0] a, input logic [15:0] d);
        wr(IDX_IND_READ, {24'h0, a});
        rd_chk(IDX_IND_DATA_LO, {24'h0, d[7:0]});
        rd_chk(IDX_IND_DATA_HI, {24'h0, d[15:8]});
    endtask : ind_chk
    task automatic ticks(input int n);
        repeat (n) @(posedge pclk iff sample_tick === 1'b1);
    endtask : ticks
    task automatic wrap_up;
        $display("Checks %0d, errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (30000) @(posedge pclk);
        err_count++;
        wrap_up();
    end

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rst_idx[i]) rd_chk(rst_idx[i], 32'h0000_0000);
        apb(1'b0, 32'h0000_01FC, 32'h0000_0000);
        chk1(err, 1'b1);
        apb(1'b1, {23'h0, IDX_ENABLE, 2'b01}, 32'h0000_00FF);
        chk1(err, 1'b1);
        rd_chk(IDX_ENABLE, 32'h0000_0000);
        wr(IDX_ENABLE, 32'h0000_00FF);
        rd_chk(IDX_ENABLE, 32'h0000_00FE);
        wr(IDX_ENABLE, 32'h0000_0000);
        wr(IDX_LC_MODE, 32'h0000_00FF);
        rd_chk(IDX_LC_MODE, 32'h0000_0005);
        wr(IDX_LC_MODE, 32'h0000_0000);
        q_power <= {8'h66, 8'h55, 8'h44, 8'h33, 8'h22, 8'h11};
        for (int p = 0; p < 8; p++) begin
            wr(IDX_PWR_SELECT, 32'(p));
            rd_chk(IDX_PWR_READOUT, (p < 6) ? 32'(8'h11 * (p + 1)) : 32'h0000_0000);
        end
        q_power <= '0;
        foreach (ind_a[i]) ind_wr(ind_a[i], ind_d[i]);
        foreach (ind_a[i]) ind_chk(ind_a[i], ind_d[i]);
        q_power[2] <= 8'h40;
        ticks(3);
        rd_chk(IDX_PENDING, 32'h0000_0010);
        chk1(irq, 1'b0);
        chk1(force_open, 1'b0);
        wr(IDX_AUTO_OPEN, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        chk1(force_open, 1'b1);
        wr(IDX_ENABLE, 32'h0000_0010);
        repeat (2) @(posedge pclk);
        chk1(irq, 1'b1);
        wr(IDX_AUTO_OPEN, 32'h0000_0000);
        wr(IDX_ENABLE, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        chk1(force_open, 1'b0);
        chk1(irq, 1'b0);
        wr(IDX_AUTO_OPEN, 32'h0000_0001);
        wr(IDX_ENABLE, 32'h0000_0010);
        q_power[2] <= 8'h00;
        ticks(3);
        chk1(force_open, 1'b0);
        rd_chk(IDX_PENDING, 32'h0000_0010);
        wr(IDX_PENDING, 32'h0000_0010);
        rd_chk(IDX_PENDING, 32'h0000_0000);
        chk1(irq, 1'b0);
        wr(IDX_AUTO_OPEN, 32'h0000_0000);
        wr(IDX_ENABLE, 32'h0000_0000);
        ind_wr(IND_LC_FILTER, 16'h7FFF);
        ind_wr(IND_LC_UPPER, 16'h0010);
        ind_wr(IND_LC_LOWER, 16'h0008);
        wr(IDX_DEBOUNCE, 32'h0000_0003);
        cur <= 7'h18;
        ticks(6);
        rd_chk(IDX_LC_SAMPLE, 32'h0000_0018);
        rd_chk(IDX_LC_STATUS, 32'h0000_0000);
        lf <= LF_FWD_ACTIVE;
        ticks(2);
        rd_chk(IDX_LC_STATUS, 32'h0000_0000);
        foreach (st_exp[i]) begin
            wr(IDX_LC_MODE, {29'h0, st_mode[i]});
            lf   <= st_lf[i];
            cur  <= st_cur[i];
            volt <= st_volt[i];
            ticks(8);
            rd_chk(IDX_LC_STATUS, {31'h0, st_exp[i]});
        end
        rd_chk(IDX_PENDING, 32'h0000_0002);
        chk1(irq, 1'b0);
        wr(IDX_ENABLE, 32'h0000_0002);
        repeat (2) @(posedge pclk);
        chk1(irq, 1'b1);
        wr(IDX_PENDING, 32'h0000_0002);
        rd_chk(IDX_PENDING, 32'h0000_0000);
        wrap_up();
    end
endmodule : line_monitor_tb
